// File: irq_tree_pkg.sv
package irq_tree_pkg;

	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int N_SL = 7;
	localparam int GPIO_PINS = 15;
	localparam int EDGE_W = 2 * GPIO_PINS;

	// second-level register index
	localparam int SL_SUPPLY = 0;
	localparam int SL_REGF = 1;
	localparam int SL_THERM = 2;
	localparam int SL_ADC = 3;
	localparam int SL_GPIO0 = 4;
	localparam int SL_GPIO1 = 5;
	localparam int SL_PBTN = 6;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] FL_PEND_OFF = 8'h02;
	localparam logic [7:0] FL_MASK_OFF = 8'h0e;
	localparam logic [7:0] FL_VALID = 8'h6a;
	localparam logic [7:0] FL_PEND_RST = 8'h00;
	localparam logic [7:0] FL_MASK_RST = 8'h6a;

	// first-level bit positions
	localparam int GRP_VR = 6;
	localparam int GRP_GPIO = 5;
	localparam int GRP_ADC = 3;
	localparam int GRP_THERMAL_GROUP_FLAG = 1;

	// per second-level register, index 6 down to 0
	localparam logic [N_SL-1:0][7:0] SL_OFF =
		{8'h07, 8'h0c, 8'h0b, 8'h06, 8'h05, 8'h04, 8'h03};
	localparam logic [N_SL-1:0][7:0] SL_MOFF =
		{8'h17, 8'h1a, 8'h19, 8'h13, 8'h12, 8'h11, 8'h10};
	localparam logic [N_SL-1:0][7:0] SL_VALID =
		{8'h01, 8'hff, 8'h7f, 8'h1f, 8'h01, 8'h01, 8'h01};
	localparam logic [N_SL-1:0][7:0] SL_MASK_RST =
		{8'h01, 8'hff, 8'h7f, 8'h1f, 8'h01, 8'h01, 8'h01};
	localparam logic [7:0] SL_FLAG_RST = 8'h00;

	// adc second-level bits and gpio0 pin count
	localparam int ADC_CH0_BIT = 0;
	localparam int ADC_TEMP_BIT = 3;
	localparam int ADC_TASK_BIT = 4;
	localparam int GPIO0_PINS = 7;

	// edge select encodings
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int IRQ_LATENCY_MAX_NS = 1000000;
	localparam int IRQ_LATENCY_MAX_CYC = IRQ_LATENCY_MAX_NS / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// top state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [N_SL-1:0][7:0] flags;
		logic [N_SL-1:0][7:0] mask2;
		logic [7:0] mask1;
		logic [7:0] pending;
		logic irq;
		logic [7:0] rdata;
		logic temp_en;
		logic task_en;
	} tree_state_s;

	localparam tree_state_s TREE_RST = '{
		flags: {N_SL{SL_FLAG_RST}},
		mask2: SL_MASK_RST,
		mask1: FL_MASK_RST,
		pending: FL_PEND_RST,
		irq: 1'b0,
		rdata: 8'h00,
		temp_en: 1'b0,
		task_en: 1'b0
	};

endpackage : irq_tree_pkg

// File: reset_release.sv
`timescale 1ns/1ps
`default_nettype none

module reset_release
(
	// clock and raw reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// released reset
	output logic rst_n_o
);

	typedef struct packed {
		logic meta;
		logic held;
	} rel_state_s;

	rel_state_s s_q;
	rel_state_s s_d;

	always_comb
	begin
		s_d.meta = 1'b1;
		s_d.held = s_q.meta;
	end

	// assert at once, release two edges later
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rst_n_o = s_q.held;

endmodule : reset_release

`default_nettype wire

// File: pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module pin_edge_detect
	import irq_tree_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// pins and their edge selection
	input wire logic [GPIO_PINS-1:0] pin_i,
	input wire logic [EDGE_W-1:0] edge_select_i,
	// one-cycle event per pin
	output logic [GPIO_PINS-1:0] event_o
);

	typedef struct packed {
		logic [GPIO_PINS-1:0] prev;
		logic primed;
	} edge_state_s;

	edge_state_s s_q;
	edge_state_s s_d;

	always_comb
	begin
		s_d.prev = pin_i;
		s_d.primed = 1'b1;
		event_o = '0;
		for (int p = 0; p < GPIO_PINS; p++)
		begin
			// no event on the first sample: prev is not yet real
			case (edge_select_i[2*p +: 2])
				EDGE_RISE: event_o[p] = s_q.primed & pin_i[p] & ~s_q.prev[p];
				EDGE_FALL: event_o[p] = s_q.primed & ~pin_i[p] & s_q.prev[p];
				EDGE_BOTH: event_o[p] = s_q.primed & (pin_i[p] ^ s_q.prev[p]);
				default: event_o[p] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

endmodule : pin_edge_detect

`default_nettype wire

// File: two_level_irq_controller.sv
// Function
// - irq is high exactly in the cycle after an unmasked first-level bit is pending.
// - irq rises within 1 ms of an interrupt condition.
// - an event sets its second-level flag, then its group flag, then irq.
// - irq falls only once no unmasked second-level flag outside the power-button register is left set in a group unmasked at first level.
// - a group masked at first level neither sets its flag nor raises irq.
// - writes to first-level flags are ignored; they follow the second level.
// - a masked second-level source never sets its flag nor propagates.
// - second-level and power-button flags are write-1-to-clear.
// - first level: regulator bit 6, gpio 5, adc 3, thermal 1, rest zero.
// - supply range, channel alerts and conversion done feed the adc group.
// - regulator fault flag feeds regulator group, cleared on cold off.
// - die temperature alert sets the thermal flag.
// - each channel 0..2 voltage alert sets its own adc flag.
// - conversion done sets its flag only if irq enable was set at request.
// - gpio flags rise on the configured edge and feed the gpio group.
// - this unit holds all second-level and power-button status and owns irq.
// - a task list requested with irq enable raises an adc flag on completion.
`timescale 1ns/1ps
`default_nettype none

module two_level_irq_controller
	import irq_tree_pkg::*;
#(
	parameter int LATENCY_MAX_CYC = IRQ_LATENCY_MAX_CYC
)
(
	// clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// register port from the i2c slave
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// adc, regulator and thermal sources
	input wire logic supply_out_of_range_i,
	input wire logic regulator_fault_i,
	input wire logic die_temp_alert_i,
	input wire logic [2:0] channel_alert_i,
	input wire logic request_irq_enable_i,
	input wire logic temp_conv_req_i,
	input wire logic temp_conv_done_i,
	input wire logic task_list_req_i,
	input wire logic task_list_done_i,
	// power state and button
	input wire logic cold_off_i,
	input wire logic power_button_i,
	// gpio inputs
	input wire logic [GPIO_PINS-1:0] gpio_pin_i,
	input wire logic [EDGE_W-1:0] edge_select_i,
	// interrupt to the host
	output logic irq_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction : hit

	// any flag of the register still unmasked
	function automatic logic live(input logic [7:0] f, input logic [7:0] m);
		return |(f & ~m);
	endfunction : live

	// ------------------------------------------------------------
	// reset release and gpio edges
	// ------------------------------------------------------------
	logic rst_n;
	logic [GPIO_PINS-1:0] gpio_event;

	reset_release u_reset_release
	(
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.rst_n_o(rst_n)
	);

	pin_edge_detect u_pin_edge_detect
	(
		.clock_i(clock_i),
		.rst_n_i(rst_n),
		.pin_i(gpio_pin_i),
		.edge_select_i(edge_select_i),
		.event_o(gpio_event)
	);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	tree_state_s s_q;
	tree_state_s s_d;
	logic [N_SL-1:0][7:0] ev;
	logic [N_SL-1:0] unm;

	// ------------------------------------------------------------
	// event collection
	// ------------------------------------------------------------
	always_comb
	begin
		ev = '0;
		ev[SL_SUPPLY][0] = supply_out_of_range_i;
		ev[SL_REGF][0] = regulator_fault_i;
		ev[SL_THERM][0] = die_temp_alert_i;
		ev[SL_ADC][ADC_CH0_BIT +: 3] = channel_alert_i;
		// enable is latched at request time, not at completion
		ev[SL_ADC][ADC_TEMP_BIT] = temp_conv_done_i & s_q.temp_en;
		ev[SL_ADC][ADC_TASK_BIT] = task_list_done_i & s_q.task_en;
		ev[SL_GPIO0][GPIO0_PINS-1:0] = gpio_event[GPIO_PINS-1:8];
		ev[SL_GPIO1] = gpio_event[7:0];
		ev[SL_PBTN][0] = power_button_i;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic [7:0] clr;
		clr = '0;
		s_d = s_q;
		for (int i = 0; i < N_SL; i++)
		begin
			clr = (reg_wr_i && hit(reg_addr_i, SL_OFF[i])) ? reg_wdata_i : 8'h00;
			// set beats a clear landing in the same cycle
			s_d.flags[i] = ((s_q.flags[i] & ~clr) | (ev[i] & ~s_q.mask2[i])) & SL_VALID[i];
			if (reg_wr_i && hit(reg_addr_i, SL_MOFF[i]))
			begin
				s_d.mask2[i] = reg_wdata_i & SL_VALID[i];
			end
			unm[i] = live(s_q.flags[i], s_q.mask2[i]);
		end
		if (cold_off_i)
		begin
			s_d.flags[SL_REGF] = SL_FLAG_RST;
		end
		if (reg_wr_i && hit(reg_addr_i, FL_MASK_OFF))
		begin
			s_d.mask1 = reg_wdata_i & FL_VALID;
		end

		// group flags follow the second level only; direct writes ignored
		s_d.pending = FL_PEND_RST;
		s_d.pending[GRP_VR] = unm[SL_REGF] & ~s_q.mask1[GRP_VR];
		s_d.pending[GRP_GPIO] = (unm[SL_GPIO0] | unm[SL_GPIO1]) & ~s_q.mask1[GRP_GPIO];
		s_d.pending[GRP_ADC] = (unm[SL_SUPPLY] | unm[SL_ADC]) & ~s_q.mask1[GRP_ADC];
		s_d.pending[GRP_THERMAL_GROUP_FLAG] = unm[SL_THERM] & ~s_q.mask1[GRP_THERMAL_GROUP_FLAG];
		s_d.irq = |(s_q.pending & ~s_q.mask1 & FL_VALID);

		if (temp_conv_req_i)
		begin
			s_d.temp_en = request_irq_enable_i;
		end
		if (task_list_req_i)
		begin
			s_d.task_en = request_irq_enable_i;
		end

		// read data stands until the next read
		if (reg_rd_i)
		begin
			s_d.rdata = 8'h00;
			if (hit(reg_addr_i, FL_PEND_OFF))
			begin
				s_d.rdata = s_q.pending;
			end
			if (hit(reg_addr_i, FL_MASK_OFF))
			begin
				s_d.rdata = s_q.mask1;
			end
			for (int i = 0; i < N_SL; i++)
			begin
				if (hit(reg_addr_i, SL_OFF[i]))
				begin
					s_d.rdata = s_q.flags[i];
				end
				if (hit(reg_addr_i, SL_MOFF[i]))
				begin
					s_d.rdata = s_q.mask2[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= TREE_RST;
		else
			s_q <= s_d;
	end

	assign irq_o = s_q.irq;
	assign reg_rdata_o = s_q.rdata;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n);

	// live unmasked source in an unmasked group, ahead of pending by a cycle
	logic grp_cause;
	assign grp_cause = (unm[SL_THERM] && !s_q.mask1[GRP_THERMAL_GROUP_FLAG])
		|| ((unm[SL_SUPPLY] || unm[SL_ADC]) && !s_q.mask1[GRP_ADC])
		|| ((unm[SL_GPIO0] || unm[SL_GPIO1]) && !s_q.mask1[GRP_GPIO])
		|| (unm[SL_REGF] && !s_q.mask1[GRP_VR]);

	// cycles such a cause has waited with irq low
	logic [31:0] wait_cnt;
	always_ff @(posedge clock_i or negedge rst_n)
	begin
		if (!rst_n)
			wait_cnt <= '0;
		else if (grp_cause && !irq_o)
			wait_cnt <= wait_cnt + 32'd1;
		else
			wait_cnt <= '0;
	end

	sequence s_therm_event;
		die_temp_alert_i && !s_q.mask2[SL_THERM][0] && !s_q.mask1[GRP_THERMAL_GROUP_FLAG] && !reg_wr_i;
	endsequence

	sequence s_therm_climb;
		s_q.flags[SL_THERM][0] ##1 s_q.pending[GRP_THERMAL_GROUP_FLAG];
	endsequence

	property p_irq_follows;
		|(s_q.pending & ~s_q.mask1) |=> irq_o;
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("irq not raised for pending unmasked group");

	property p_irq_falls;
		!(|(s_q.pending & ~s_q.mask1)) |=> !irq_o;
	endproperty
	a_irq_falls: assert property (p_irq_falls)
		else $error("irq high with nothing pending");

	property p_latency;
		wait_cnt < LATENCY_MAX_CYC;
	endproperty
	a_latency: assert property (p_latency)
		else $error("irq latency above limit");

	property p_chain;
		s_therm_event ##1 !reg_wr_i |-> s_therm_climb ##1 irq_o;
	endproperty
	a_chain: assert property (p_chain)
		else $error("thermal event did not climb to irq");

	property p_group_mask;
		s_q.mask1[GRP_ADC] && $past(s_q.mask1[GRP_ADC]) |-> !s_q.pending[GRP_ADC];
	endproperty
	a_group_mask: assert property (p_group_mask)
		else $error("masked group flag set");

	property p_no_direct_clear;
		$fell(s_q.pending[GRP_VR]) |-> $past(!unm[SL_REGF] || s_q.mask1[GRP_VR]);
	endproperty
	a_no_direct_clear: assert property (p_no_direct_clear)
		else $error("group flag cleared with live source");

	property p_masked_source;
		!s_q.flags[SL_THERM][0] && s_q.mask2[SL_THERM][0] |=> !s_q.flags[SL_THERM][0];
	endproperty
	a_masked_source: assert property (p_masked_source)
		else $error("masked source set its flag");

	property p_w1c;
		reg_wr_i && hit(reg_addr_i, SL_OFF[SL_THERM]) && !die_temp_alert_i
			|=> s_q.flags[SL_THERM][0] == ($past(s_q.flags[SL_THERM][0]) && !$past(reg_wdata_i[0]));
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write-1-to-clear misbehaved");

	property p_cold_off;
		cold_off_i |=> s_q.flags[SL_REGF] == SL_FLAG_RST;
	endproperty
	a_cold_off: assert property (p_cold_off)
		else $error("fault flag survived cold off");

	property p_temp_gate;
		$rose(s_q.flags[SL_ADC][ADC_TEMP_BIT]) |-> $past(temp_conv_done_i && s_q.temp_en);
	endproperty
	a_temp_gate: assert property (p_temp_gate)
		else $error("conversion flag set without enable");

	property p_task_gate;
		$rose(s_q.flags[SL_ADC][ADC_TASK_BIT]) |-> $past(task_list_done_i && s_q.task_en);
	endproperty
	a_task_gate: assert property (p_task_gate)
		else $error("task list flag set without enable");

	property p_enable_latch;
		temp_conv_req_i |=> s_q.temp_en == $past(request_irq_enable_i);
	endproperty
	a_enable_latch: assert property (p_enable_latch)
		else $error("conversion enable not latched at request");

	property p_adc_group;
		(unm[SL_SUPPLY] || unm[SL_ADC]) && !s_q.mask1[GRP_ADC] |=> s_q.pending[GRP_ADC];
	endproperty
	a_adc_group: assert property (p_adc_group)
		else $error("adc group flag missing");

	property p_vr_group;
		unm[SL_REGF] && !s_q.mask1[GRP_VR] |=> s_q.pending[GRP_VR];
	endproperty
	a_vr_group: assert property (p_vr_group)
		else $error("regulator group flag missing");

	// first sample after reset never counts as an edge
	sequence s_pin0_rise;
		edge_select_i[1:0] == EDGE_RISE && $rose(gpio_pin_i[0]) && $past(rst_n);
	endsequence

	property p_gpio_rise;
		s_pin0_rise |-> gpio_event[0];
	endproperty
	a_gpio_rise: assert property (p_gpio_rise)
		else $error("rising pin edge not detected");

	property p_gpio_fall;
		edge_select_i[1:0] == EDGE_FALL && $fell(gpio_pin_i[0]) && $past(rst_n) |-> gpio_event[0];
	endproperty
	a_gpio_fall: assert property (p_gpio_fall)
		else $error("falling pin edge not detected");

	property p_gpio_flag;
		gpio_event[0] && !s_q.mask2[SL_GPIO1][0] |=> s_q.flags[SL_GPIO1][0];
	endproperty
	a_gpio_flag: assert property (p_gpio_flag)
		else $error("pin event did not set its flag");

endmodule : two_level_irq_controller

`default_nettype wire

// File: soc_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------
// soc side: register host on the device's register port
// ----------------
module soc_host_model
(
	// clock
	input wire logic clock_i,
	// answers from the device
	input wire logic [7:0] rdata_i,
	// register strobes
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	initial
	begin
		addr_o = 8'h00;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	// one register write, used for masks and for write-1 acknowledges of second-level flags
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(posedge clock_i);
		#1;
		wr_o = 1'b0;
		// stale values must not look like a held bus
		addr_o = ~a;
		wdata_o = ~d;
	endtask : wr

	// one register read: rd high for one cycle, data sampled at the edge after rd drops
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i);
		#1;
		addr_o = a;
		rd_o = 1'b1;
		@(posedge clock_i);
		#1;
		rd_o = 1'b0;
		addr_o = ~a;
		@(posedge clock_i);
		d = rdata_i;
		#1;
	endtask : rd
endmodule : soc_host_model

`default_nettype wire

// File: two_level_irq_controller_test.sv
`timescale 1ns/1ps
`default_nettype none

module two_level_irq_controller_test import irq_tree_pkg::*;;
	// ----------------
	// stimulus and bookkeeping
	// ----------------
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	// 0 supply,1 fault,2 die,3 treq,4 tdone,5 lreq,6 ldone,7 cold,8 button,11:9 channels
	logic [11:0] ev = 12'h000;
	logic [GPIO_PINS-1:0] pins = '0;
	logic [EDGE_W-1:0] edges = '0;
	logic irq_en = 1'b0;
	logic [7:0] addr, wdata, rdata, v;
	logic wr, rd, irq;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;

	always #10 clock_i = ~clock_i;

	two_level_irq_controller #(.LATENCY_MAX_CYC(100)) dut (
		.clock_i(clock_i), .rstn_i(rstn_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.supply_out_of_range_i(ev[0]), .regulator_fault_i(ev[1]), .die_temp_alert_i(ev[2]),
		.channel_alert_i(ev[11:9]), .request_irq_enable_i(irq_en),
		.temp_conv_req_i(ev[3]), .temp_conv_done_i(ev[4]),
		.task_list_req_i(ev[5]), .task_list_done_i(ev[6]),
		.cold_off_i(ev[7]), .power_button_i(ev[8]),
		.gpio_pin_i(pins), .edge_select_i(edges), .irq_o(irq));

	soc_host_model host (.clock_i(clock_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	// ----------------
	// helpers
	// ----------------
	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic settle();
		repeat (5) @(posedge clock_i);
		#1;
	endtask : settle

	task automatic pulse(input logic [11:0] m);
		@(posedge clock_i);
		#1 ev = m;
		@(posedge clock_i);
		#1 ev = 12'h000;
		settle();
	endtask : pulse

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, v);
		check(v, e);
	endtask : expect_reg

	task automatic expect_irq(input logic e);
		check({7'h00, irq}, {7'h00, e});
	endtask : expect_irq

	// hang guard, well above the few hundred cycles needed
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			results();
		end
	end

	// ----------------
	// scenarios
	// ----------------
	initial
	begin
		repeat (10) @(posedge clock_i);
		#1 rstn_i = 1'b1;
		settle();
		expect_reg(FL_MASK_OFF, FL_MASK_RST);
		expect_reg(FL_PEND_OFF, 8'h00);
		expect_reg(8'h30, 8'h00);
		expect_irq(1'b0);
		host.wr(FL_MASK_OFF, 8'h68);
		host.wr(SL_MOFF[SL_THERM], 8'h00);
		pulse(12'h004);
		expect_irq(1'b1);
		expect_reg(FL_PEND_OFF, 8'h02);
		expect_reg(SL_OFF[SL_THERM], 8'h01);
		host.wr(FL_PEND_OFF, 8'hff);
		expect_reg(FL_PEND_OFF, 8'h02);
		host.wr(SL_OFF[SL_THERM], 8'h00);
		settle();
		expect_irq(1'b1);
		host.wr(SL_OFF[SL_THERM], 8'h01);
		settle();
		expect_irq(1'b0);
		host.wr(SL_MOFF[SL_THERM], 8'h01);
		pulse(12'h004);
		expect_reg(SL_OFF[SL_THERM], 8'h00);
		host.wr(SL_MOFF[SL_THERM], 8'h00);
		host.wr(FL_MASK_OFF, 8'h6a);
		pulse(12'h004);
		expect_reg(FL_PEND_OFF, 8'h00);
		expect_irq(1'b0);
		host.wr(SL_OFF[SL_THERM], 8'h01);
		// adc group: channels, supply range, conversions
		host.wr(FL_MASK_OFF, 8'h62);
		host.wr(SL_MOFF[SL_ADC], 8'h00);
		host.wr(SL_MOFF[SL_SUPPLY], 8'h00);
		pulse(12'ha00);
		expect_reg(SL_OFF[SL_ADC], 8'h05);
		pulse(12'h400);
		expect_reg(SL_OFF[SL_ADC], 8'h07);
		expect_irq(1'b1);
		pulse(12'h001);
		expect_reg(SL_OFF[SL_SUPPLY], 8'h01);
		host.wr(SL_OFF[SL_ADC], 8'h07);
		settle();
		expect_irq(1'b1);
		host.wr(SL_OFF[SL_SUPPLY], 8'h01);
		settle();
		expect_irq(1'b0);
		pulse(12'h008);
		pulse(12'h010);
		expect_reg(SL_OFF[SL_ADC], 8'h00);
		irq_en = 1'b1;
		pulse(12'h008);
		irq_en = 1'b0;
		pulse(12'h010);
		expect_reg(SL_OFF[SL_ADC], 8'h08);
		irq_en = 1'b1;
		pulse(12'h020);
		pulse(12'h040);
		expect_reg(SL_OFF[SL_ADC], 8'h18);
		host.wr(SL_OFF[SL_ADC], 8'h18);
		// regulator fault and cold off
		host.wr(FL_MASK_OFF, 8'h2a);
		host.wr(SL_MOFF[SL_REGF], 8'h00);
		pulse(12'h002);
		expect_reg(FL_PEND_OFF, 8'h40);
		pulse(12'h080);
		expect_reg(SL_OFF[SL_REGF], 8'h00);
		expect_irq(1'b0);
		// power button is status only
		host.wr(SL_MOFF[SL_PBTN], 8'h00);
		pulse(12'h100);
		expect_reg(SL_OFF[SL_PBTN], 8'h01);
		expect_irq(1'b0);
		host.wr(SL_OFF[SL_PBTN], 8'h01);
		expect_reg(SL_OFF[SL_PBTN], 8'h00);
		// every edge code on pin 0, rise then fall
		host.wr(FL_MASK_OFF, 8'h4a);
		host.wr(SL_MOFF[SL_GPIO1], 8'hfe);
		for (int k = 0; k < 4; k++)
		begin
			edges[1:0] = k[1:0];
			pins[0] = 1'b1;
			settle();
			expect_irq(k[0]);
			expect_reg(SL_OFF[SL_GPIO1], {7'h00, k[0]});
			host.wr(SL_OFF[SL_GPIO1], 8'h01);
			pins[0] = 1'b0;
			settle();
			expect_reg(SL_OFF[SL_GPIO1], {7'h00, k[1]});
			host.wr(SL_OFF[SL_GPIO1], 8'h01);
		end
		// upper register: pin 14 on a rising edge
		host.wr(SL_MOFF[SL_GPIO0], 8'h3f);
		edges[29:28] = EDGE_RISE;
		pins[14] = 1'b1;
		settle();
		expect_irq(1'b1);
		expect_reg(SL_OFF[SL_GPIO0], 8'h40);
		host.wr(SL_OFF[SL_GPIO0], 8'h40);
		settle();
		expect_irq(1'b0);
		// reset in mid-run with irq raised
		host.wr(FL_MASK_OFF, 8'h2a);
		pulse(12'h002);
		expect_irq(1'b1);
		rstn_i = 1'b0;
		repeat (2) @(posedge clock_i);
		#1;
		expect_irq(1'b0);
		rstn_i = 1'b1;
		settle();
		expect_reg(FL_MASK_OFF, 8'h6a);
		expect_reg(SL_OFF[SL_REGF], 8'h00);
		results();
	end
endmodule : two_level_irq_controller_test

`default_nettype wire
